// [bench/srs_status_regs_tb.sv]
// Purpose: self-checking bench for the receiver status register group
// Assumes: inputs driven 1 ns after the rising edge, fixed random seed
// Notes:   expectations come from bench-side models, never from the design
`timescale 1ns/1ps
module srs_status_regs_tb;
  import srs_pkg::*;

  logic        clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic        rate_detect_enable_i, rate_locked_i, level_b_flag_i;
  logic [2:0]  rate_code_i, active_stream_count_i;
  logic [3:0]  t_rate_i, t_family_i, edh_packet_flag_set_i;
  logic        t_scan_i, t_locked_i, high_frame_rate_flag_i;
  logic        edh_pkt_valid_i, edh_packet_checksum_error_i, field_end_i;
  logic [4:0]  edh_ancillary_flag_set_i, edh_full_field_flag_set_i;
  logic [4:0]  edh_active_picture_flag_set_i;
  logic        ancillary_checksum_error_i, full_field_crc_mismatch_i;
  logic        active_picture_crc_mismatch_i;
  logic [15:0] crc_err_i, flags, ev, w, ecnt, ccnt;
  logic [31:0] seed;
  logic [31:0] r;
  int          miscompares, compares;
  logic [2:0]  rc [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  srs_status_regs DUT (.*);

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // read answer lands on the same edge that takes the strobe
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(posedge clk_sys_i);
    #1 reg_rd_i = 1'b0;
    chk({31'h0, reg_rvalid_o}, 32'h1);
    chk(reg_rdata_o, exp);
    // one idle edge so the next strobe never rises in the step it fell
    tick();
  endtask : rdc

  // expected rate status word; lock reads one while detection is off
  function automatic logic [31:0] exp_rate(input logic lb, input logic [2:0] act,
                                           input logic en, input logic lk,
                                           input logic [2:0] rate);
    return {24'h0, lb, act, en ? lk : 1'b1, rate};
  endfunction : exp_rate

  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(posedge clk_sys_i);
    #1 reg_wr_i = 1'b0;
  endtask : wr

  task tick();
    @(posedge clk_sys_i);
    #1;
  endtask : tick

  // edh packet with event vector {chksum, ap, ff, anc}
  task pkt(input logic [15:0] e);
    edh_packet_checksum_error_i   = e[15];
    edh_active_picture_flag_set_i = e[14:10];
    edh_full_field_flag_set_i     = e[9:5];
    edh_ancillary_flag_set_i      = e[4:0];
    edh_packet_flag_set_i         = 4'($random(seed));
    edh_pkt_valid_i               = 1'b1;
    tick();
    edh_pkt_valid_i = 1'b0;
  endtask : pkt

  task fend();
    field_end_i = 1'b1;
    tick();
    field_end_i = 1'b0;
  endtask : fend

  task complete_run();
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    seed = 32'ha6f8191b;
    miscompares = 0;
    compares = 0;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {rate_detect_enable_i, rate_code_i, rate_locked_i} = '0;
    active_stream_count_i = 3'h1;
    level_b_flag_i = 1'b0;
    {t_rate_i, t_scan_i, t_locked_i} = '0;
    t_family_i = 4'hF;
    high_frame_rate_flag_i = 1'b1;
    {edh_pkt_valid_i, edh_packet_checksum_error_i, edh_packet_flag_set_i} = '0;
    {edh_ancillary_flag_set_i, edh_full_field_flag_set_i} = '0;
    edh_active_picture_flag_set_i = 5'h00;
    {ancillary_checksum_error_i, full_field_crc_mismatch_i} = '0;
    {active_picture_crc_mismatch_i, field_end_i, crc_err_i} = '0;
    sys_rst_i = 1'b1;
    repeat (12) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    // reset defaults and an unmapped place
    rdc(RATE_STS_OFS, 32'h18);
    rdc(TRANSPORT_STS_OFS, 32'hF4);
    rdc(EDH_STS_OFS, 32'h0);
    rdc(EDH_MASK_OFS, 32'h0);
    rdc(EDH_COUNT_OFS, 32'h0);
    rdc(CRC_ERR_OFS, 32'h0);
    rdc(8'h00, 32'h0);
    // every line rate and stream code, detection on and off
    for (int i = 0; i < 12; i++)
    begin
      rate_code_i = rc[i % 6];
      active_stream_count_i = 3'(i % 5);
      rate_detect_enable_i = i[0];
      rate_locked_i = 1'($random(seed));
      level_b_flag_i = 1'($random(seed));
      tick();
      rdc(RATE_STS_OFS, exp_rate(level_b_flag_i, active_stream_count_i,
          rate_detect_enable_i, rate_locked_i, rate_code_i));
    end
    for (int i = 0; i < 8; i++)
    begin
      {t_rate_i, t_family_i, t_scan_i, t_locked_i, high_frame_rate_flag_i} = 11'($random(seed));
      tick();
      rdc(TRANSPORT_STS_OFS, {20'h0, t_rate_i, t_family_i, 1'b0,
          high_frame_rate_flag_i, t_scan_i, t_locked_i});
    end
    // mask keeps only its sixteen bits; read-only places ignore writes
    r = $random(seed);
    wr(EDH_MASK_OFS, r);
    rdc(EDH_MASK_OFS, {16'h0, r[15:0]});
    wr(EDH_STS_OFS, 32'hFFFFFFFF);
    rdc(EDH_STS_OFS, 32'h0);
    // sd mode: each mask bit counts only its own event, once per field
    rate_code_i = 3'h1;
    ecnt = 16'h0;
    tick();
    for (int k = 0; k < 16; k++)
    begin
      ev = 16'h1 << k;
      wr(EDH_MASK_OFS, {16'h0, ev});
      {ancillary_checksum_error_i, full_field_crc_mismatch_i} = 2'($random(seed));
      active_picture_crc_mismatch_i = 1'($random(seed));
      pkt(~ev);
      fend();
      rdc(EDH_COUNT_OFS, {16'h0, ecnt});
      pkt(ev);
      rdc(EDH_STS_OFS, {9'h0, edh_packet_flag_set_i, ev[4:0], ev[9:5], ev[14:10], 1'b0,
          ancillary_checksum_error_i, full_field_crc_mismatch_i,
          active_picture_crc_mismatch_i});
      pkt(ev);
      fend();
      ecnt++;
      rdc(EDH_COUNT_OFS, {16'h0, ecnt});
    end
    // two packets in one field still count once; hd mode never counts
    pkt(ev);
    tick();
    field_end_i = 1'b1;
    pkt(ev);
    field_end_i = 1'b0;
    ecnt++;
    rdc(EDH_COUNT_OFS, {16'h0, ecnt});
    rate_code_i = 3'h0;
    tick();
    pkt(ev);
    fend();
    rdc(EDH_COUNT_OFS, {16'h0, ecnt});
    // crc flags and count, with write-one clears between bursts
    flags = 16'h0;
    ccnt = 16'h0;
    for (int i = 0; i < 24; i++)
    begin
      crc_err_i = (i % 3 == 0) ? 16'hFFFF : 16'($random(seed));
      tick();
      flags = flags | crc_err_i;
      ccnt = ccnt + 16'($countones(crc_err_i));
      crc_err_i = 16'h0;
      rdc(CRC_ERR_OFS, {ccnt, flags});
      w = 16'($random(seed));
      wr(CRC_ERR_OFS, {16'hFFFF, w});
      flags = flags & ~w;
      rdc(CRC_ERR_OFS, {ccnt, flags});
    end
    // clear of stream one coinciding with its new error keeps the flag
    crc_err_i = 16'h1;
    tick();
    crc_err_i = 16'h0;
    wr(CRC_ERR_OFS, 32'h0);
    flags = flags | 16'h1;
    rdc(CRC_ERR_OFS, {ccnt + 16'h1, flags});
    crc_err_i = 16'h1;
    wr(CRC_ERR_OFS, 32'h1);
    crc_err_i = 16'h0;
    rdc(CRC_ERR_OFS, {ccnt + 16'h2, flags});
    wr(CRC_ERR_OFS, 32'h1);
    rdc(CRC_ERR_OFS, {ccnt + 16'h2, flags & 16'hFFFE});
    complete_run();
  end

endmodule : srs_status_regs_tb

// [verilog/srs_pkg.sv]
// Purpose: constants for the receiver status register group
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   offsets and most field positions and reset values live here
package srs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0]  RATE_STS_OFS       = 8'h44;
  localparam logic [7:0]  TRANSPORT_STS_OFS  = 8'h48;
  localparam logic [7:0]  EDH_STS_OFS        = 8'h4C;
  localparam logic [7:0]  EDH_MASK_OFS       = 8'h50;
  localparam logic [7:0]  EDH_COUNT_OFS      = 8'h54;
  localparam logic [7:0]  CRC_ERR_OFS        = 8'h58;

  ////////////////////////////////////////////////////////////////////////////
  // rate detect status fields
  localparam int          LEVEL_B_POS        = 7;
  localparam int          ACT_STREAMS_LSB    = 4;
  localparam int          RATE_LOCK_POS      = 3;
  localparam int          RATE_CODE_LSB      = 0;
  localparam logic [2:0]  ACT_STREAMS_RST    = 3'h1;
  localparam logic        RATE_LOCK_RST      = 1'h1;
  localparam logic [2:0]  RATE_CODE_RST      = 3'h0;
  localparam logic [2:0]  RATE_CODE_SD       = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // transport detect status fields
  localparam int          T_RATE_LSB         = 8;
  localparam int          T_FAMILY_LSB       = 4;
  localparam int          HFR_POS            = 2;
  localparam int          T_SCAN_POS         = 1;
  localparam int          T_LOCK_POS         = 0;
  localparam logic [3:0]  T_RATE_RST         = 4'h0;
  localparam logic [3:0]  T_FAMILY_RST       = 4'hF;
  localparam logic        HFR_RST            = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // edh result status fields
  localparam int          EDH_PKT_LSB        = 19;
  localparam int          EDH_ANC_FLAG_LSB   = 14;
  localparam int          EDH_FF_FLAG_LSB    = 9;
  localparam int          EDH_AP_FLAG_LSB    = 4;
  localparam int          EDH_ANC_ERR_POS    = 2;
  localparam int          EDH_FF_ERR_POS     = 1;
  localparam int          EDH_AP_ERR_POS     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // mask, counters, crc flags
  localparam int          MASK_W             = 16;
  localparam logic [15:0] MASK_RST           = 16'h0000;
  localparam logic [15:0] COUNT_RST          = 16'h0000;
  localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
  localparam int          STREAMS            = 16;
  localparam int          CRC_CNT_LSB        = 16;

endpackage : srs_pkg

// [verilog/srs_status_regs.sv]
// Purpose: status and error registers of the sdi receiver
// Assumes: status inputs are synchronous to clk_sys_i; edh and crc events are pulses
// Notes:   reads answer one cycle after the read strobe; unmapped reads return zero
//
// Operation
// - active stream count codes 1..16 streams as 000..100, reset code two streams
// - rate lock reads one when rate detection is disabled
// - line rate code reports hd, sd, 3g, 6g, 12g variants; resets to hd
// - level b flag bit 7 follows incoming 3g level b
// - transport frame rate field reports transport rate, valid with transport lock
// - transport family field reports family, valid with lock, resets all ones
// - transport scan low interlaced, high progressive, valid with lock
// - transport lock bit 0 high once transport format identified
// - high frame rate flag bit 2, reset value one
// - hold packet, ancillary, full-field and active-picture flags of last edh packet
// - ancillary status bit 2 high on ancillary checksum error
// - bit 1 high on full-field crc mismatch
// - bit 0 high on active-picture crc mismatch
// - sixteen writable mask bits: checksum, active picture, full field, ancillary
// - sd mode counter adds one per field with enabled error, holding at 16'hFFFF
// - upper half holds cumulative crc error count, read only
// - bits 15 to 1 sticky crc flags for streams 16 to 2, write one clears
// - bit 0 sticky crc flag for stream 1, write one clears
// - rate detect enable bit gates real rate lock reporting
`timescale 1ns/1ps
module srs_status_regs
  import srs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  // core control
  input  wire logic        rate_detect_enable_i,
  // rate detection
  input  wire logic [2:0]  rate_code_i,
  input  wire logic        rate_locked_i,
  input  wire logic [2:0]  active_stream_count_i,
  input  wire logic        level_b_flag_i,
  // transport detection
  input  wire logic [3:0]  t_rate_i,
  input  wire logic [3:0]  t_family_i,
  input  wire logic        t_scan_i,
  input  wire logic        t_locked_i,
  input  wire logic        high_frame_rate_flag_i,
  // edh results
  input  wire logic        edh_pkt_valid_i,
  input  wire logic        edh_packet_checksum_error_i,
  input  wire logic [3:0]  edh_packet_flag_set_i,
  input  wire logic [4:0]  edh_ancillary_flag_set_i,
  input  wire logic [4:0]  edh_full_field_flag_set_i,
  input  wire logic [4:0]  edh_active_picture_flag_set_i,
  input  wire logic        ancillary_checksum_error_i,
  input  wire logic        full_field_crc_mismatch_i,
  input  wire logic        active_picture_crc_mismatch_i,
  input  wire logic        field_end_i,
  // per-stream crc errors
  input  wire logic [15:0] crc_err_i
);

  logic [2:0]  rate_code_r;
  logic        rate_lock_r;
  logic [2:0]  act_streams_r;
  logic        level_b_r;
  logic [3:0]  t_rate_r;
  logic [3:0]  t_family_r;
  logic        t_scan_r;
  logic        t_lock_r;
  logic        hfr_r;
  logic [3:0]  pkt_flags_r;
  logic [4:0]  anc_flags_r;
  logic [4:0]  ff_flags_r;
  logic [4:0]  ap_flags_r;
  logic        anc_err_r;
  logic        ff_err_r;
  logic        ap_err_r;
  logic [15:0] mask_r;
  logic [15:0] edh_cnt_r;
  logic        field_err_r;
  logic [15:0] crc_cnt_r;
  logic [15:0] crc_flags;
  logic [15:0] crc_clr;
  logic [15:0] edh_evt;
  logic        edh_hit;
  logic        sd_mode;
  logic [4:0]  crc_pop;
  logic [16:0] crc_sum;
  logic [31:0] rd_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // rate detection status
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rate_code_r   <= RATE_CODE_RST;
      rate_lock_r   <= RATE_LOCK_RST;
      act_streams_r <= ACT_STREAMS_RST;
      level_b_r     <= 1'h0;
    end
    else
    begin
      rate_code_r   <= rate_code_i;
      rate_lock_r   <= rate_detect_enable_i ? rate_locked_i : 1'h1;
      act_streams_r <= active_stream_count_i;
      level_b_r     <= level_b_flag_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transport detection status; fields mean nothing until lock rises
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      t_rate_r   <= T_RATE_RST;
      t_family_r <= T_FAMILY_RST;
      t_scan_r   <= 1'h0;
      t_lock_r   <= 1'h0;
      hfr_r      <= HFR_RST;
    end
    else
    begin
      t_rate_r   <= t_rate_i;
      t_family_r <= t_family_i;
      t_scan_r   <= t_scan_i;
      t_lock_r   <= t_locked_i;
      hfr_r      <= high_frame_rate_flag_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edh packet flags, held until the next packet
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pkt_flags_r <= '0;
      anc_flags_r <= '0;
      ff_flags_r  <= '0;
      ap_flags_r  <= '0;
    end
    else if (edh_pkt_valid_i)
    begin
      pkt_flags_r <= edh_packet_flag_set_i;
      anc_flags_r <= edh_ancillary_flag_set_i;
      ff_flags_r  <= edh_full_field_flag_set_i;
      ap_flags_r  <= edh_active_picture_flag_set_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edh check results
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      anc_err_r <= 1'h0;
      ff_err_r  <= 1'h0;
      ap_err_r  <= 1'h0;
    end
    else
    begin
      anc_err_r <= ancillary_checksum_error_i;
      ff_err_r  <= full_field_crc_mismatch_i;
      ap_err_r  <= active_picture_crc_mismatch_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edh count enable mask
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      mask_r <= MASK_RST;
    else if (reg_wr_i && reg_addr_i == EDH_MASK_OFS)
      mask_r <= reg_wdata_i[MASK_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-field edh error counting
  // mask bit order
  assign edh_evt = {edh_packet_checksum_error_i, edh_active_picture_flag_set_i,
                    edh_full_field_flag_set_i, edh_ancillary_flag_set_i}
                   & {MASK_W{edh_pkt_valid_i}} & mask_r;
  assign edh_hit = |edh_evt;
  assign sd_mode = (rate_code_r == RATE_CODE_SD);

  // errors are remembered until field end so several hits count once
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      field_err_r <= 1'h0;
    else if (field_end_i)
      field_err_r <= 1'h0;
    else if (edh_hit)
      field_err_r <= 1'h1;
  end

  // counter saturates instead of wrapping so a long bad run never reads small
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      edh_cnt_r <= COUNT_RST;
    else if (field_end_i && sd_mode && (field_err_r || edh_hit) && edh_cnt_r != COUNT_MAX)
      edh_cnt_r <= edh_cnt_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-stream crc flags and cumulative count
  function automatic logic [4:0] srs_popcount(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < STREAMS; i++)
      n = n + {4'h0, v[i]};
    return n;
  endfunction : srs_popcount

  assign crc_clr = (reg_wr_i && reg_addr_i == CRC_ERR_OFS) ? reg_wdata_i[15:0] : 16'h0000;

  srs_sticky_bank #(
    .W         (STREAMS)
  ) u_crc_flags (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (crc_err_i),
    .clr_i     (crc_clr),
    .flag_o    (crc_flags)
  );

  assign crc_pop = srs_popcount(crc_err_i);
  assign crc_sum = {1'h0, crc_cnt_r} + {12'h000, crc_pop};

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      crc_cnt_r <= COUNT_RST;
    else
      crc_cnt_r <= crc_sum[16] ? COUNT_MAX : crc_sum[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr_i)
      RATE_STS_OFS:
      begin
        rd_nxt[LEVEL_B_POS]                    = level_b_r;
        rd_nxt[ACT_STREAMS_LSB +: 3]           = act_streams_r;
        rd_nxt[RATE_LOCK_POS]                  = rate_lock_r;
        rd_nxt[RATE_CODE_LSB +: 3]             = rate_code_r;
      end
      TRANSPORT_STS_OFS:
      begin
        rd_nxt[T_RATE_LSB +: 4]                = t_rate_r;
        rd_nxt[T_FAMILY_LSB +: 4]              = t_family_r;
        rd_nxt[HFR_POS]                        = hfr_r;
        rd_nxt[T_SCAN_POS]                     = t_scan_r;
        rd_nxt[T_LOCK_POS]                     = t_lock_r;
      end
      EDH_STS_OFS:
      begin
        rd_nxt[EDH_PKT_LSB +: 4]               = pkt_flags_r;
        rd_nxt[EDH_ANC_FLAG_LSB +: 5]          = anc_flags_r;
        rd_nxt[EDH_FF_FLAG_LSB +: 5]           = ff_flags_r;
        rd_nxt[EDH_AP_FLAG_LSB +: 5]           = ap_flags_r;
        rd_nxt[EDH_ANC_ERR_POS]                = anc_err_r;
        rd_nxt[EDH_FF_ERR_POS]                 = ff_err_r;
        rd_nxt[EDH_AP_ERR_POS]                 = ap_err_r;
      end
      EDH_MASK_OFS:  rd_nxt[MASK_W-1:0]        = mask_r;
      EDH_COUNT_OFS: rd_nxt[15:0]              = edh_cnt_r;
      CRC_ERR_OFS:   rd_nxt                    = {crc_cnt_r, crc_flags};
      default:       rd_nxt                    = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'h0;
    end
    else
    begin
      reg_rdata_o  <= reg_rd_i ? rd_nxt : reg_rdata_o;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_defaults: assert property (
    $fell(sys_rst_i) |-> (act_streams_r == 3'h1 && rate_code_r == 3'h0 && rate_lock_r))
    else $error("rate status reset values wrong");

  a_lock_forced: assert property (
    !rate_detect_enable_i |=> rate_lock_r)
    else $error("rate lock not forced high while detection off");

  a_lock_real: assert property (
    (rate_detect_enable_i && !rate_locked_i) |=> !rate_lock_r)
    else $error("rate lock high while detection reports unlocked");

  a_rate_follows: assert property (
    ##1 (rate_code_r == $past(rate_code_i) && level_b_r == $past(level_b_flag_i)))
    else $error("rate code or level b not tracking input");

  a_transport_reset: assert property (
    $fell(sys_rst_i) |-> (t_family_r == 4'hF && hfr_r && !t_lock_r))
    else $error("transport status reset values wrong");

  a_transport_follows: assert property (
    ##1 (t_lock_r == $past(t_locked_i) && t_scan_r == $past(t_scan_i)
         && t_rate_r == $past(t_rate_i)))
    else $error("transport status not tracking input");

  a_edh_capture: assert property (
    edh_pkt_valid_i |=> (ap_flags_r == $past(edh_active_picture_flag_set_i)
                         && pkt_flags_r == $past(edh_packet_flag_set_i))
    ##1 ($past(edh_pkt_valid_i) || $stable(ap_flags_r)))
    else $error("edh packet flags not held");

  a_edh_results: assert property (
    ##1 ({anc_err_r, ff_err_r, ap_err_r} == $past({ancillary_checksum_error_i,
          full_field_crc_mismatch_i, active_picture_crc_mismatch_i})))
    else $error("edh result bits not tracking");

  a_mask_write: assert property (
    (reg_wr_i && reg_addr_i == EDH_MASK_OFS) |=> mask_r == $past(reg_wdata_i[15:0]))
    else $error("mask write not stored");

  a_count_step: assert property (
    (field_end_i && sd_mode && (field_err_r || edh_hit) && edh_cnt_r != 16'hFFFF)
    |=> edh_cnt_r == $past(edh_cnt_r) + 16'h0001)
    else $error("edh counter did not step once");

  a_count_hold: assert property (
    (!field_end_i || !sd_mode) |=> $stable(edh_cnt_r))
    else $error("edh counter moved outside sd field end");

  a_crc_count: assert property (
    (crc_err_i == 16'h0001 && crc_cnt_r != 16'hFFFF) |=> crc_cnt_r == $past(crc_cnt_r) + 16'h0001)
    else $error("crc count did not add one error");

  a_crc_clear: assert property (
    (reg_wr_i && reg_addr_i == CRC_ERR_OFS && reg_wdata_i[15] && !crc_err_i[15])
    |=> !crc_flags[15])
    else $error("crc flag 16 not cleared");

  a_crc_sticky: assert property (
    crc_err_i[0] |=> crc_flags[0] [*2] or (crc_flags[0] ##1 $past(crc_clr[0])))
    else $error("crc flag 1 not sticky");

  // read answers next cycle
  a_read_answer: assert property (
    reg_rd_i |=> (reg_rvalid_o && reg_rdata_o == $past(rd_nxt)))
    else $error("read answer late or wrong");

  c_lock_forced:  cover property (!rate_detect_enable_i ##1 rate_lock_r);
  c_edh_count:    cover property (field_end_i && sd_mode && field_err_r);
  c_crc_clash:    cover property (crc_err_i[0] && crc_clr[0]);
  c_edh_packet:   cover property (edh_pkt_valid_i && edh_hit);

endmodule : srs_status_regs

// [verilog/srs_sticky_bank.sv]
// Purpose: bank of sticky flags, set by hardware, cleared by writing one
// Assumes: set and clear are one-cycle pulses in the system clock domain
// Notes:   a set in the same cycle as a clear keeps the flag set
`timescale 1ns/1ps
module srs_sticky_bank #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  // events and clears
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // flags
  output logic      [W-1:0] flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // set beats clear
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      flag_o <= '0;
    else
      flag_o <= (flag_o & ~clr_i) | set_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // set wins check
  a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (set_i != '0) |=> ((flag_o & $past(set_i)) == $past(set_i)))
    else $error("sticky flag lost on coinciding set");

  a_zero_keeps: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (clr_i == '0) |=> ((flag_o & $past(flag_o)) == $past(flag_o)))
    else $error("sticky flag dropped without clear");

endmodule : srs_sticky_bank
